// *** include/sdram_link_if.sv ***
// command, address, data and mask wires between controller and memory
// assumes both ends share clk; data pins are three signals each
`timescale 1ns/100ps
`default_nettype none
interface sdram_link_if;
    import sdram_wp_pkg::*;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [addr_w-1:0] addr;
    logic bank_select_low;
    logic bank_select_high;
    logic dqm;
    logic [data_w-1:0] dq_ctl_out;
    logic dq_ctl_oe_n;
    logic [data_w-1:0] dq_mem_out;
    logic dq_mem_oe_n;
    logic [data_w-1:0] dq;
    assign dq = !dq_ctl_oe_n ? dq_ctl_out : (!dq_mem_oe_n ? dq_mem_out : '0);
    modport memory(input cke, cs_n, ras_n, cas_n, we_n, addr, bank_select_low, bank_select_high,
                   dqm, dq, output dq_mem_out, dq_mem_oe_n);
    modport controller(output cke, cs_n, ras_n, cas_n, we_n, addr, bank_select_low,
                       bank_select_high, dqm, dq_ctl_out, dq_ctl_oe_n, input dq);
endinterface
`default_nettype wire

// *** include/sdram_wp_pkg.sv ***
// constants and types shared by the memory-side and controller-side ends
// assumes a single 100 MHz clock on both ends
package sdram_wp_pkg;
    localparam int clk_period_ns = 10;
    localparam int write_recovery_time_ns = 15;
    localparam int precharge_period_ns = 20;
    // least times round up
    localparam int wr_cycles = (write_recovery_time_ns + clk_period_ns - 1) / clk_period_ns;
    localparam int rp_cycles = (precharge_period_ns + clk_period_ns - 1) / clk_period_ns;
    localparam int cnt_w = 4;
    localparam logic [cnt_w-1:0] wr_cnt = cnt_w'(wr_cycles);
    localparam logic [cnt_w-1:0] rp_cnt = cnt_w'(rp_cycles);
    localparam int data_w = 16;
    localparam int addr_w = 13;
    localparam int col_w = 9;
    localparam int banks = 4;
    localparam int precharge_all_bit = 10;
    localparam int page_len = 512;
    localparam int blen_w = 10;
    localparam logic [blen_w-1:0] blen_full = 10'h3ff;
    localparam int mem_words = 256;
    localparam int mem_aw = 8;
    localparam logic [1:0] bank_zero = 2'h0;

    // cs_n, ras_n, cas_n, we_n
    localparam logic [3:0] cmd_nop = 4'h7;
    localparam logic [3:0] cmd_active = 4'h3;
    localparam logic [3:0] cmd_read = 4'h5;
    localparam logic [3:0] cmd_write = 4'h4;
    localparam logic [3:0] cmd_precharge = 4'h2;
    localparam logic [3:0] cmd_terminate = 4'h6;

    typedef enum logic [1:0] {bank_idle, bank_active, bank_precharging} bank_state_type;
    typedef enum logic [2:0] {req_none, req_activate, req_write, req_read, req_precharge,
                              req_terminate} req_type;
endpackage

// *** verif/sdram_wp_chk.sv ***
// checker: link wires and memory-end outputs around write bursts and precharge
// assumes one clock, clk, and the asynchronous active-high reset rst
`timescale 1ns/100ps
`default_nettype none
module sdram_wp_chk
    import sdram_wp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [addr_w-1:0] addr,
    input wire logic bank_select_low,
    input wire logic bank_select_high,
    input wire logic dqm,
    input wire logic [data_w-1:0] dq,
    input wire logic write_strobe,
    input wire logic [data_w-1:0] write_data,
    input wire logic [banks-1:0] bank_open,
    input wire logic [banks-1:0] bank_busy
);
    localparam int busy_max = 4;
    logic [3:0] cmd;
    logic [1:0] sel;
    assign cmd = {cs_n, ras_n, cas_n, we_n};
    assign sel = {bank_select_high, bank_select_low};

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // ----------------------------------------
    // sequences
    // ----------------------------------------
    // an edge only counts when the gate was high one edge earlier
    sequence s_live(logic [3:0] c);
        $past(cke) && cmd == c;
    endsequence
    sequence s_read_quiet;
        s_live(cmd_read) ##1 (cmd != cmd_write) [*2];
    endsequence

    // ----------------------------------------
    // properties
    // ----------------------------------------
    a_reset_idle_link: assert property ($fell(rst) |-> !cke && dqm && cmd == cmd_nop ##1 cke)
        else $error("link not idle after reset");
    a_write_first_word: assert property ((s_live(cmd_write) ##0 !dqm) |=> write_strobe && write_data == $past(dq))
        else $error("first write word not stored");
    a_mask_drops_word: assert property (dqm |=> !write_strobe)
        else $error("masked word stored");
    a_gate_low_ignored: assert property (!$past(cke) |=> !write_strobe)
        else $error("word stored on suspended edge");
    a_term_drops_word: assert property (s_live(cmd_terminate) |=> !write_strobe)
        else $error("word stored on terminate edge");
    a_read_stops_write: assert property (s_read_quiet |-> !$past(write_strobe) && !write_strobe ##1 !write_strobe)
        else $error("write continued after read");
    a_close_all_banks: assert property ((s_live(cmd_precharge) ##0 addr[precharge_all_bit]) |-> ##2 bank_open == '0)
        else $error("bank left open after close-all");
    a_close_one_bank: assert property ((s_live(cmd_precharge) ##0 !addr[precharge_all_bit])
        |-> ##2 !bank_open[$past(sel, 2)])
        else $error("selected bank left open");
    a_busy_bounded: assert property ($rose(bank_busy[0]) |-> ##[1:busy_max] !bank_busy[0])
        else $error("bank stays precharging too long");
endmodule
`default_nettype wire

// *** verif/sdram_write_precharge_control_bench.sv ***
// bench: controller and memory ends face each other over the link
// assumes the package, link interface, both ends and the checker are compiled first
`timescale 1ns/100ps
`default_nettype none
module sdram_write_precharge_control_bench;
    import sdram_wp_pkg::*;
    logic clk, rst, req_valid, req_auto, req_all, req_mask, suspend, ready;
    logic write_strobe, rnd_mask, live_r, m_on, mask_hi;
    req_type req_kind;
    logic [1:0] req_bank, write_bank, m_bank;
    logic [addr_w-1:0] req_addr;
    logic [data_w-1:0] req_data, rd_sample, write_data;
    logic [blen_w-1:0] burst_len;
    logic [mem_aw-1:0] write_addr;
    logic [banks-1:0] bank_open, bank_busy;
    logic [3:0] cmd_now;
    logic [5:0] m_col;
    logic [25:0] notes[$];
    int m_left, num_errors, checks;

    sdram_link_if lk();
    assign cmd_now = {lk.cs_n, lk.ras_n, lk.cas_n, lk.we_n};
    sdram_wp_memory sdram_wp_memory_inst(.clk(clk), .rst(rst), .link(lk), .burst_len(burst_len),
        .write_strobe(write_strobe), .write_bank(write_bank), .write_addr(write_addr),
        .write_data(write_data), .bank_open(bank_open), .bank_busy(bank_busy));
    sdram_wp_controller sdram_wp_controller_inst(.clk(clk), .rst(rst), .link(lk), .req_valid(req_valid),
        .req_kind(req_kind), .req_bank(req_bank), .req_addr(req_addr), .req_auto(req_auto),
        .req_all(req_all), .req_data(req_data), .req_mask(req_mask), .suspend(suspend),
        .ready(ready), .rd_sample(rd_sample));
    sdram_wp_chk chk(.clk(clk), .rst(rst), .cke(lk.cke), .cs_n(lk.cs_n), .ras_n(lk.ras_n),
        .cas_n(lk.cas_n), .we_n(lk.we_n), .addr(lk.addr), .bank_select_low(lk.bank_select_low),
        .bank_select_high(lk.bank_select_high), .dqm(lk.dqm), .dq(lk.dq), .write_strobe(write_strobe),
        .write_data(write_data), .bank_open(bank_open), .bank_busy(bank_busy));

    // ----------------------------------------
    // clock, data stream, reference model
    // ----------------------------------------
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        req_data <= 16'($urandom);
        req_mask <= mask_hi | (rnd_mask ? 1'($urandom) : 1'h0);
    end

    // model of the storing side, fed from the wires it sees
    always @(posedge clk) begin
        if (rst) begin
            live_r = 1'h0;
            m_on = 1'h0;
        end else begin
            if (live_r && cmd_now == cmd_write) begin
                m_on = 1'h1;
                m_bank = {lk.bank_select_high, lk.bank_select_low};
                m_col = lk.addr[5:0];
                m_left = (burst_len == blen_full) ? 32'h7fffffff : int'(burst_len);
            end else if (live_r && (cmd_now == cmd_read || cmd_now == cmd_terminate)) begin
                m_on = 1'h0;
            end
            if (live_r && m_on) begin
                if (lk.dqm !== 1'h1) begin
                    notes.push_back({m_bank, m_bank, m_col, lk.dq});
                end
                m_col++;
                m_left--;
                m_on = (m_left > 0);
            end
            live_r = lk.cke;
        end
    end

    always @(posedge clk) begin
        if (!rst && write_strobe === 1'h1) begin
            if (notes.size() == 0)
                check(32'h1, 32'h0);
            else
                check({write_bank, write_addr, write_data}, notes.pop_front());
        end
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // the hold after a precharge is invisible, so callers leave gaps
    task automatic issue(input req_type k, input logic [1:0] b, input logic [addr_w-1:0] a,
                         input logic au, input logic al, input logic [3:0] code);
        int n;
        n = 0;
        while (ready !== 1'h1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n >= 50) num_errors++;
        req_valid <= 1'h1;
        req_kind <= k;
        req_bank <= b;
        req_addr <= a;
        req_auto <= au;
        req_all <= al;
        @(posedge clk);
        req_valid <= 1'h0;
        @(posedge clk);
        check(cmd_now, code);
    endtask

    task automatic wait_open(input int b, input logic exp);
        int n;
        n = 0;
        while (bank_open[b] !== exp && n < 12) begin
            @(posedge clk);
            n++;
        end
        check(bank_open[b], exp);
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        wrap_up();
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        void'($urandom(32'hf347f43c));
        {rst, req_valid, req_auto, req_all, suspend, rnd_mask, mask_hi} = 7'h40;
        req_kind = req_none;
        req_bank = 2'h0;
        req_addr = 13'h0;
        burst_len = 10'h2;
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        repeat (2) @(posedge clk);
        for (int b = 0; b < 4; b++) issue(req_activate, 2'(b), 13'h11, 1'h0, 1'h0, cmd_active);
        repeat (2) @(posedge clk);
        check(bank_open, 4'hf);
        issue(req_write, 2'h1, 13'h0, 1'h0, 1'h0, cmd_write);
        issue(req_write, 2'h1, 13'h2, 1'h0, 1'h0, cmd_write);
        burst_len <= 10'h4;
        issue(req_write, 2'h1, 13'h10, 1'h0, 1'h0, cmd_write);
        issue(req_write, 2'h1, 13'h20, 1'h0, 1'h0, cmd_write);
        repeat (4) @(posedge clk);
        rnd_mask <= 1'h1;
        issue(req_write, 2'h3, 13'h8, 1'h0, 1'h0, cmd_write);
        repeat (4) @(posedge clk);
        rnd_mask <= 1'h0;
        issue(req_write, 2'h3, 13'h30, 1'h0, 1'h0, cmd_write);
        suspend <= 1'h1;
        repeat (2) @(posedge clk);
        suspend <= 1'h0;
        repeat (6) @(posedge clk);
        burst_len <= blen_full;
        issue(req_write, 2'h2, 13'h0, 1'h0, 1'h0, cmd_write);
        repeat (5) @(posedge clk);
        issue(req_terminate, 2'h0, 13'h0, 1'h0, 1'h0, cmd_terminate);
        repeat (4) @(posedge clk);
        burst_len <= 10'h4;
        issue(req_write, 2'h1, 13'h3c, 1'h0, 1'h0, cmd_write);
        issue(req_read, 2'h2, 13'h0, 1'h0, 1'h0, cmd_read);
        repeat (4) @(posedge clk);
        // keep one element, mask the rest, close after write recovery
        mask_hi <= 1'h1;
        issue(req_write, 2'h3, 13'h4, 1'h0, 1'h0, cmd_write);
        issue(req_precharge, 2'h3, 13'h0, 1'h0, 1'h0, cmd_precharge);
        wait_open(3, 1'h0);
        mask_hi <= 1'h0;
        issue(req_precharge, 2'h3, 13'h0, 1'h0, 1'h0, cmd_precharge);
        check(bank_open, 4'h7);
        issue(req_precharge, 2'h1, 13'h0, 1'h0, 1'h1, cmd_precharge);
        repeat (2) @(posedge clk);
        check(bank_open, 4'h0);
        // plain auto close, then auto write and auto read cut by another bank
        for (int i = 0; i < 3; i++) begin
            repeat (8) @(posedge clk);
            issue(req_activate, 2'h0, 13'h22, 1'h0, 1'h0, cmd_active);
            issue(req_activate, 2'h1, 13'h33, 1'h0, 1'h0, cmd_active);
            burst_len <= (i == 0) ? 10'h2 : 10'h4;
            if (i < 2)
                issue(req_write, 2'h0, 13'h4, 1'h1, 1'h0, cmd_write);
            else
                issue(req_read, 2'h0, 13'h4, 1'h1, 1'h0, cmd_read);
            if (i > 0)
                issue(req_write, 2'h1, 13'h8, 1'h0, 1'h0, cmd_write);
            wait_open(0, 1'h0);
            check(bank_open[1], 1'h1);
            repeat (6) @(posedge clk);
            issue(req_precharge, 2'h0, 13'h0, 1'h0, 1'h1, cmd_precharge);
        end
        repeat (6) @(posedge clk);
        check(notes.size(), 32'h0);
        check(bank_busy, 4'h0);
        wrap_up();
    end
endmodule
`default_nettype wire

// *** verilog/sdram_wp_controller.sv ***
// controller end: turns one request at a time into link commands
// assumes a memory end on the same clk; caller waits for ready
`timescale 1ns/100ps
`default_nettype none
module sdram_wp_controller
    import sdram_wp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    sdram_link_if.controller link,
    input wire logic req_valid,
    input wire req_type req_kind,
    input wire logic [1:0] req_bank,
    input wire logic [addr_w-1:0] req_addr,
    input wire logic req_auto,
    input wire logic req_all,
    input wire logic [data_w-1:0] req_data,
    input wire logic req_mask,
    input wire logic suspend,
    output logic ready,
    output logic [data_w-1:0] rd_sample
);
    logic [cnt_w-1:0] hold_r [banks];
    logic [3:0] cmd_r;
    logic [addr_w-1:0] addr_r;
    logic [1:0] bank_r;
    logic dqm_r;
    logic [data_w-1:0] dout_r;
    logic oe_n_r;
    logic cke_r;
    logic bank_ok;
    logic take;
    logic [3:0] cmd_nxt;
    logic [addr_w-1:0] addr_nxt;

    // ------------------------------------------------------------
    // request to command
    // ------------------------------------------------------------
    // activate and accesses wait for hold_r of their bank: rp_cnt after a precharge, wr_cnt + rp_cnt from an auto-precharge command
    assign bank_ok = hold_r[req_bank] == '0;
    // a command must land on an edge the memory treats as live
    assign take = req_valid && ready && !suspend && cke_r &&
                  (bank_ok || req_kind == req_precharge || req_kind == req_terminate);

    always_comb begin
        cmd_nxt = cmd_nop;
        addr_nxt = req_addr;
        case (req_kind)
            req_activate: cmd_nxt = cmd_active;
            req_write: begin
                cmd_nxt = cmd_write;
                addr_nxt[precharge_all_bit] = req_auto;
            end
            req_read: begin
                cmd_nxt = cmd_read;
                addr_nxt[precharge_all_bit] = req_auto;
            end
            req_precharge: begin
                cmd_nxt = cmd_precharge;
                addr_nxt[precharge_all_bit] = req_all;
            end
            req_terminate: cmd_nxt = cmd_terminate;
            default: cmd_nxt = cmd_nop;
        endcase
        if (!take) begin
            cmd_nxt = cmd_nop;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_r <= cmd_nop;
            addr_r <= '0;
            bank_r <= bank_zero;
            cke_r <= 1'b0;
        end else begin
            cmd_r <= cmd_nxt;
            addr_r <= addr_nxt;
            bank_r <= req_bank;
            cke_r <= !suspend;
        end
    end

    // ------------------------------------------------------------
    // data and mask
    // ------------------------------------------------------------
    // caller keeps mask high during recovery before a truncating precharge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dqm_r <= 1'b1;
            dout_r <= '0;
            oe_n_r <= 1'b1;
        end else begin
            dqm_r <= req_mask;
            dout_r <= req_data;
            // memory never drives back, so data stands for the whole burst unless masked
            oe_n_r <= req_mask;
        end
    end

    // ------------------------------------------------------------
    // per-bank hold-off
    // ------------------------------------------------------------
    genvar b;
    generate
        for (b = 0; b < banks; b++) begin : g_hold
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    hold_r[b] <= '0;
                end else if (take && req_kind == req_precharge && (req_all || req_bank == b)) begin
                    hold_r[b] <= rp_cnt;
                end else if (take && req_auto && req_bank == b &&
                             (req_kind == req_write || req_kind == req_read)) begin
                    hold_r[b] <= cnt_w'(wr_cnt + rp_cnt);
                end else if (hold_r[b] != '0) begin
                    hold_r[b] <= hold_r[b] - cnt_w'(1);
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ready <= 1'b0;
            rd_sample <= '0;
        end else begin
            ready <= 1'b1;
            rd_sample <= link.dq;
        end
    end

    assign link.cke = cke_r;
    assign {link.cs_n, link.ras_n, link.cas_n, link.we_n} = cmd_r;
    assign link.addr = addr_r;
    assign link.bank_select_low = bank_r[0];
    assign link.bank_select_high = bank_r[1];
    assign link.dqm = dqm_r;
    assign link.dq_ctl_out = dout_r;
    assign link.dq_ctl_oe_n = oe_n_r;
endmodule
`default_nettype wire

// *** verilog/sdram_wp_memory.sv ***
// memory end: command decode, write bursts, per-bank row and precharge state
// assumes the link pins are driven by a controller on the same clk
//
// Behaviour
// - write accepted any edge after previous write
// - controller truncates write after wanted element count
// - truncation only within the same die
// - terminate ends non-auto-precharge write, drops data
// - full-page write ends only by terminate or read
// - clock gate low suspends capture, extends burst
// - mask high discards data, burst continues
// - read stops write capture from its edge
// - precharge waits write recovery after last data
// - mask data during recovery before truncating precharge
// - no activate before precharge period elapses
// - terminate cuts latest burst, any bank
// - precharge one bank or all by select bit
// - precharged bank needs activate before access
// - precharge of idle/precharging bank is nop
// - auto precharge bank at burst end
// - controller waits precharge period after auto precharge; its hold counts wr_cnt + rp_cnt from the command, whatever the burst length
// - other-bank access interrupts auto precharge concurrently
// - read interrupt starts old precharge at read
// - write interrupt starts old precharge at write
// - write interrupted: precharge recovery after new command
// - first data on write edge, then every edge
// - decode write and read from strobe pattern
`timescale 1ns/100ps
`default_nettype none
module sdram_wp_memory
    import sdram_wp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    sdram_link_if.memory link,
    input wire logic [blen_w-1:0] burst_len,
    output logic write_strobe,
    output logic [1:0] write_bank,
    output logic [mem_aw-1:0] write_addr,
    output logic [data_w-1:0] write_data,
    output logic [banks-1:0] bank_open,
    output logic [banks-1:0] bank_busy
);
    logic [data_w-1:0] mem_r [mem_words];
    logic cke_prev_r;
    logic [3:0] cmd;
    logic live;
    logic is_write;
    logic is_read;
    logic is_pre;
    logic is_act;
    logic is_term;
    logic [1:0] bank;
    logic wr_on_r;
    logic wr_ap_r;
    logic [1:0] wr_bank_r;
    logic [col_w-1:0] wr_col_r;
    logic [blen_w-1:0] wr_left_r;
    logic rd_ap_r;
    logic [1:0] rd_bank_r;
    logic [blen_w-1:0] rd_left_r;
    logic capture;
    logic [col_w-1:0] cap_col;
    logic [1:0] cap_bank;
    bank_state_type state_r [banks];
    logic [cnt_w-1:0] timer_r [banks];
    logic [banks-1:0] ap_pend_r;
    logic [cnt_w-1:0] ap_wait_r [banks];

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    // suspended edges are ignored by command decode and bursts; bank timers still count
    assign live = cke_prev_r;
    assign cmd = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
    assign bank = {link.bank_select_high, link.bank_select_low};
    assign is_write = live && cmd == cmd_write;
    assign is_read = live && cmd == cmd_read;
    assign is_pre = live && cmd == cmd_precharge;
    assign is_act = live && cmd == cmd_active;
    assign is_term = live && cmd == cmd_terminate;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cke_prev_r <= 1'b0;
        end else begin
            cke_prev_r <= link.cke;
        end
    end

    // ------------------------------------------------------------
    // write burst
    // ------------------------------------------------------------
    // a new write restarts the burst at once, so data flows gap-free
    always_comb begin
        capture = 1'b0;
        cap_col = wr_col_r;
        cap_bank = wr_bank_r;
        if (is_write) begin
            capture = 1'b1;
            cap_col = link.addr[col_w-1:0];
            cap_bank = bank;
        end else if (live && wr_on_r && !is_read && !is_term) begin
            capture = 1'b1;
        end
        if (link.dqm) begin
            capture = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_on_r <= 1'b0;
            wr_ap_r <= 1'b0;
            wr_bank_r <= bank_zero;
            wr_col_r <= '0;
            wr_left_r <= '0;
        end else if (live) begin
            if (is_write) begin
                wr_on_r <= burst_len != blen_w'(1);
                wr_ap_r <= link.addr[precharge_all_bit];
                wr_bank_r <= bank;
                wr_col_r <= link.addr[col_w-1:0] + col_w'(1);
                wr_left_r <= burst_len - blen_w'(1);
            end else if (is_read || (is_term && !wr_ap_r)) begin
                wr_on_r <= 1'b0;
            end else if (wr_on_r) begin
                wr_col_r <= wr_col_r + col_w'(1);
                // full page never self-ends
                if (burst_len != blen_full) begin
                    wr_left_r <= wr_left_r - blen_w'(1);
                    if (wr_left_r == blen_w'(1)) begin
                        wr_on_r <= 1'b0;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (capture) begin
            mem_r[{cap_bank, cap_col[mem_aw-3:0]}] <= link.dq;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            write_strobe <= 1'b0;
            write_bank <= bank_zero;
            write_addr <= '0;
            write_data <= '0;
        end else begin
            write_strobe <= capture;
            write_bank <= cap_bank;
            write_addr <= {cap_bank, cap_col[mem_aw-3:0]};
            write_data <= link.dq;
        end
    end

    // read burst only followed for its auto precharge point
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_ap_r <= 1'b0;
            rd_bank_r <= bank_zero;
            rd_left_r <= '0;
        end else if (live) begin
            if (is_read) begin
                rd_ap_r <= link.addr[precharge_all_bit];
                rd_bank_r <= bank;
                rd_left_r <= burst_len;
            end else if (rd_left_r != '0 && burst_len != blen_full) begin
                rd_left_r <= rd_left_r - blen_w'(1);
            end
            if (is_write || (is_term && !rd_ap_r)) begin
                rd_left_r <= '0;
            end
        end
    end

    assign link.dq_mem_out = '0;
    assign link.dq_mem_oe_n = 1'b1;

    // ------------------------------------------------------------
    // per-bank state
    // ------------------------------------------------------------
    genvar b;
    generate
        for (b = 0; b < banks; b++) begin : g_bank
            logic hit_pre;
            logic wr_end;
            logic rd_end;
            logic intr;
            assign hit_pre = is_pre && (link.addr[precharge_all_bit] || bank == b);
            // auto precharge of a write waits write recovery after the last data
            // a single-element write closes from its own edge
            assign wr_end = (wr_on_r && wr_ap_r && wr_bank_r == b && live && !is_write && !is_read
                             && burst_len != blen_full && wr_left_r == blen_w'(1))
                            || (is_write && link.addr[precharge_all_bit] && bank == b
                                && burst_len == blen_w'(1));
            assign intr = (is_write || is_read) && bank != b;
            assign rd_end = rd_ap_r && rd_bank_r == b && live &&
                            ((rd_left_r == blen_w'(1) && burst_len != blen_full && !is_read)
                             || (rd_left_r != '0 && intr));

            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    ap_pend_r[b] <= 1'b0;
                    ap_wait_r[b] <= '0;
                end else if (wr_end || (wr_on_r && wr_ap_r && wr_bank_r == b && intr)) begin
                    ap_pend_r[b] <= 1'b1;
                    ap_wait_r[b] <= wr_cnt;
                end else if (ap_pend_r[b]) begin
                    ap_wait_r[b] <= ap_wait_r[b] - cnt_w'(1);
                    if (ap_wait_r[b] == cnt_w'(1)) begin
                        ap_pend_r[b] <= 1'b0;
                    end
                end
            end

            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    state_r[b] <= bank_idle;
                    timer_r[b] <= '0;
                end else begin
                    case (state_r[b])
                        bank_idle: begin
                            if (is_act && bank == b) begin
                                state_r[b] <= bank_active;
                            end
                        end
                        bank_active: begin
                            if (hit_pre || rd_end || (ap_pend_r[b] && ap_wait_r[b] == cnt_w'(1))) begin
                                state_r[b] <= bank_precharging;
                                timer_r[b] <= rp_cnt;
                            end
                        end
                        bank_precharging: begin
                            // a second precharge here changes nothing
                            timer_r[b] <= timer_r[b] - cnt_w'(1);
                            if (timer_r[b] == cnt_w'(1)) begin
                                state_r[b] <= bank_idle;
                            end
                        end
                        default: begin
                            state_r[b] <= bank_idle;
                        end
                    endcase
                end
            end

            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    bank_open[b] <= 1'b0;
                    bank_busy[b] <= 1'b0;
                end else begin
                    bank_open[b] <= state_r[b] == bank_active;
                    bank_busy[b] <= state_r[b] == bank_precharging;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire
